// ### rtl/egp_top.sv
// Eight-pin general-purpose port with a classic Wishbone register slave.
// Function
// - Direction register is write-only; reading it returns a fixed zero.
// - Direction bit one drives a general-purpose pin as output.
// - Direction bit zero releases a general-purpose pin as input.
// - Readable, writable output latch supplies the value driven on pins.
// - Pin-state read returns latch bit where direction is one.
// - Pin-state read returns sampled pin level where direction is zero.
// - Pin-state register ignores writes; reset value follows pin levels.
// - Open-drain bit one: output only pulls low, else releases.
// - Open-drain bit zero: push-pull drives both high and low.
// - Eight pins, each with direction, latch, state and open-drain bits.
`default_nettype none
`include "egp_consts.svh"
module egp_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire egp_pkg::egp_byte_t pin_i,
	output egp_pkg::egp_byte_t pin_o,
	output egp_pkg::egp_byte_t pin_oe,
	input wire egp_pkg::egp_byte_t periph_sel,
	input wire egp_pkg::egp_byte_t periph_out,
	input wire egp_pkg::egp_byte_t periph_oe,
	output egp_pkg::egp_byte_t periph_in
);
	import egp_pkg::*;

	egp_bus_t bus_reg;
	egp_bus_t bus_next;
	egp_byte_t dir_reg;
	egp_byte_t latch_reg;
	egp_byte_t od_reg;
	egp_byte_t pin_o_reg;
	egp_byte_t pin_oe_reg;
	egp_byte_t dir_next;
	egp_byte_t latch_next;
	egp_byte_t od_next;
	egp_byte_t level_sync;
	egp_byte_t readback;
	egp_byte_t drive_val;
	egp_byte_t drive_en;
	egp_byte_t pad_oe_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic req;
	logic wr_commit;
	logic lane_ok;
	egp_reg_t sel_reg_now;

	////////////////////////////////////////////////////////////////////////
	// Pin input synchronisers, one per pin
	genvar gi;
	generate
		for (gi = 0; gi < `EGP_PINS; gi++) begin : g_pin
			egp_sync u_sync (
				.mclk(mclk),
				.nrst(nrst),
				.ce(ce),
				.pin(pin_i[gi]),
				.level(level_sync[gi])
			);
		end
	endgenerate

	// Peripherals see the filtered pin levels as well
	assign periph_in = level_sync;

	////////////////////////////////////////////////////////////////////////
	// Bus decode; write lands on the edge that the master sees ack
	assign req = wb_cyc_i && wb_stb_i;
	assign sel_reg_now = egp_decode(wb_adr_i);
	assign lane_ok = wb_sel_i[`EGP_LANE];
	assign wr_commit = (bus_reg == EGP_BUS_ACK) && req && wb_we_i && lane_ok;

	// Bus state machine: one wait cycle, then ack for one cycle
	always_comb begin
		bus_next = bus_reg;
		case (bus_reg)
			EGP_BUS_IDLE: begin
				if (req) begin
					bus_next = EGP_BUS_ACK;
				end
			end
			EGP_BUS_ACK: bus_next = EGP_BUS_IDLE;
			default: bus_next = EGP_BUS_IDLE;
		endcase
	end

	// Pin-state view: latch for outputs, pin level for inputs
	assign readback = (dir_reg & latch_reg) | (~dir_reg & level_sync);

	// Read mux; direction reads a fixed filler, unmapped reads zero
	always_comb begin
		rdata_next = `EGP_ZERO_WORD;
		case (sel_reg_now)
			EGP_REG_DIR: rdata_next = {`EGP_UPPER_ZERO, `EGP_DIR_READ};
			EGP_REG_LATCH: rdata_next = {`EGP_UPPER_ZERO, latch_reg};
			EGP_REG_LEVEL: rdata_next = {`EGP_UPPER_ZERO, readback};
			EGP_REG_OD: rdata_next = {`EGP_UPPER_ZERO, od_reg};
			default: rdata_next = `EGP_ZERO_WORD;
		endcase
	end

	// Register write paths; the pin-state offset has no storage to hit
	assign dir_next = (wr_commit && sel_reg_now == EGP_REG_DIR) ? wb_dat_i[`EGP_MSB:0] : dir_reg;
	assign latch_next = (wr_commit && sel_reg_now == EGP_REG_LATCH) ? wb_dat_i[`EGP_MSB:0] : latch_reg;
	assign od_next = (wr_commit && sel_reg_now == EGP_REG_OD) ? wb_dat_i[`EGP_MSB:0] : od_reg;

	// Bus and register flops, all frozen by ce
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_reg <= EGP_BUS_IDLE;
			rdata_reg <= `EGP_ZERO_WORD;
			dir_reg <= `EGP_RST_BYTE;
			latch_reg <= `EGP_RST_BYTE;
			od_reg <= `EGP_RST_BYTE;
		end else if (ce) begin
			bus_reg <= bus_next;
			if (bus_reg == EGP_BUS_IDLE && req) begin
				rdata_reg <= rdata_next;
			end
			dir_reg <= dir_next;
			latch_reg <= latch_next;
			od_reg <= od_next;
		end
	end

	assign wb_ack_o = (bus_reg == EGP_BUS_ACK);
	assign wb_dat_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Output stage: owner select, then push-pull or open-drain
	assign drive_val = (periph_sel & periph_out) | (~periph_sel & latch_reg);
	assign drive_en = (periph_sel & periph_oe) | (~periph_sel & dir_reg);
	// Open-drain only enables while the value is low; the pad pull-up does the high
	assign pad_oe_next = drive_en & (~od_reg | ~drive_val);

	// Registered pad drive keeps glitches off the pins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_o_reg <= `EGP_RST_BYTE;
			pin_oe_reg <= `EGP_RST_BYTE;
		end else if (ce) begin
			pin_o_reg <= drive_val;
			pin_oe_reg <= pad_oe_next;
		end
	end

	assign pin_o = pin_o_reg;
	assign pin_oe = pin_oe_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	egp_byte_t gp_out_m;
	egp_byte_t gp_in_m;
	egp_byte_t od_hi_m;
	egp_byte_t pp_m;
	egp_byte_t od_lo_m;
	assign gp_out_m = ~periph_sel & dir_reg;
	assign gp_in_m = ~periph_sel & ~dir_reg;
	assign od_hi_m = ~periph_sel & dir_reg & od_reg & latch_reg;
	assign pp_m = ~periph_sel & dir_reg & ~od_reg;
	assign od_lo_m = ~periph_sel & dir_reg & od_reg & ~latch_reg;

	dir_read_fill_a: assert property (
		(ce && bus_reg == EGP_BUS_IDLE && req && !wb_we_i && sel_reg_now == EGP_REG_DIR)
		|=> wb_ack_o && wb_dat_o == {`EGP_UPPER_ZERO, `EGP_DIR_READ})
		else $error("direction read returned other than filler");

	out_drive_a: assert property (
		ce |=> (pin_oe & ($past(gp_out_m) & ~$past(od_reg))) == ($past(gp_out_m) & ~$past(od_reg)))
		else $error("output pin not driven");

	in_release_a: assert property (
		ce |=> (pin_oe & $past(gp_in_m)) == `EGP_RST_BYTE)
		else $error("input pin driven");

	latch_write_a: assert property (
		(ce && wr_commit && sel_reg_now == EGP_REG_LATCH)
		|=> latch_reg == $past(wb_dat_i[`EGP_MSB:0]) ##1 (!ce || (pin_o & ~periph_sel) == (latch_reg & ~periph_sel)))
		else $error("latch write not stored or not driven");

	level_read_a: assert property (
		(ce && bus_reg == EGP_BUS_IDLE && req && !wb_we_i && sel_reg_now == EGP_REG_LEVEL)
		|=> wb_ack_o && wb_dat_o[`EGP_MSB:0] == (($past(dir_reg) & $past(latch_reg)) | (~$past(dir_reg) & $past(level_sync))))
		else $error("pin-state read mismatch");

	level_ro_a: assert property (
		(ce && wr_commit && sel_reg_now == EGP_REG_LEVEL)
		|=> $stable(dir_reg) && $stable(latch_reg) && $stable(od_reg))
		else $error("write to pin-state changed a register");

	od_release_a: assert property (
		ce |=> (pin_oe & $past(od_hi_m)) == `EGP_RST_BYTE)
		else $error("open-drain pin driven high");

	pp_drive_a: assert property (
		ce |=> (pin_oe & $past(pp_m)) == $past(pp_m) && (pin_o & $past(pp_m)) == ($past(latch_reg) & $past(pp_m)))
		else $error("push-pull pin level wrong");

	periph_follow_a: assert property (
		ce |=> (pin_o & $past(periph_sel)) == ($past(periph_out) & $past(periph_sel)))
		else $error("peripheral pin not followed");

	// A frozen clock enable legally stretches ack, so only a running edge ends it
	ack_one_cycle_a: assert property (
		(wb_ack_o && ce) |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	////////////////////////////////////////////////////////////////////////
	// Bus-side checks: what lands, what is refused, what the read data hold

	// Direction write lands at the ack edge and touches nothing else
	dir_write_a: assert property (
		(ce && wr_commit && sel_reg_now == EGP_REG_DIR)
		|=> dir_reg == $past(wb_dat_i[`EGP_MSB:0]) && $stable(latch_reg) && $stable(od_reg))
		else $error("direction write not stored");

	// Open-drain select write lands alone
	od_write_a: assert property (
		(ce && wr_commit && sel_reg_now == EGP_REG_OD)
		|=> od_reg == $past(wb_dat_i[`EGP_MSB:0]) && $stable(dir_reg) && $stable(latch_reg))
		else $error("open-drain write not stored");

	// Low lane off: the write is acked but must not land
	lane_refuse_a: assert property (
		(ce && bus_reg == EGP_BUS_ACK && req && wb_we_i && !lane_ok)
		|=> $stable(dir_reg) && $stable(latch_reg) && $stable(od_reg))
		else $error("write without low lane changed a register");

	// Unmapped offsets have no storage behind them
	unmapped_write_a: assert property (
		(ce && wr_commit && sel_reg_now == EGP_REG_NONE)
		|=> $stable(dir_reg) && $stable(latch_reg) && $stable(od_reg))
		else $error("unmapped write changed a register");

	// Reads never disturb the registers
	read_no_effect_a: assert property (
		(ce && bus_reg == EGP_BUS_IDLE && req && !wb_we_i)
		|=> $stable(dir_reg) && $stable(latch_reg) && $stable(od_reg))
		else $error("read changed a register");

	// Unmapped reads answer with zero
	unmapped_read_a: assert property (
		(ce && bus_reg == EGP_BUS_IDLE && req && !wb_we_i && sel_reg_now == EGP_REG_NONE)
		|=> wb_ack_o && wb_dat_o == `EGP_ZERO_WORD)
		else $error("unmapped read not zero");

	// Latch reads back what is stored
	latch_read_a: assert property (
		(ce && bus_reg == EGP_BUS_IDLE && req && !wb_we_i && sel_reg_now == EGP_REG_LATCH)
		|=> wb_ack_o && wb_dat_o == {`EGP_UPPER_ZERO, $past(latch_reg)})
		else $error("latch read mismatch");

	// Open-drain select reads back what is stored
	od_read_a: assert property (
		(ce && bus_reg == EGP_BUS_IDLE && req && !wb_we_i && sel_reg_now == EGP_REG_OD)
		|=> wb_ack_o && wb_dat_o == {`EGP_UPPER_ZERO, $past(od_reg)})
		else $error("open-drain read mismatch");

	// Only the low byte ever carries data
	upper_zero_a: assert property (
		wb_dat_o == {`EGP_UPPER_ZERO, wb_dat_o[`EGP_MSB:0]})
		else $error("read data upper bytes not zero");

	// Read data move only when a request is taken
	rdata_hold_a: assert property (
		(ce && !(bus_reg == EGP_BUS_IDLE && req)) |=> $stable(wb_dat_o))
		else $error("read data changed without a request");

	// Ack only answers a request taken while idle
	ack_after_take_a: assert property (
		$rose(wb_ack_o) |-> $past(req) && $past(bus_reg == EGP_BUS_IDLE))
		else $error("ack without a taken request");

	////////////////////////////////////////////////////////////////////////
	// Clock-enable freeze: nothing moves while ce is low

	freeze_regs_a: assert property (
		!ce |=> $stable(dir_reg) && $stable(latch_reg) && $stable(od_reg))
		else $error("register moved while frozen");

	freeze_bus_a: assert property (
		!ce |=> $stable(wb_ack_o) && $stable(wb_dat_o))
		else $error("bus outputs moved while frozen");

	freeze_pins_a: assert property (
		!ce |=> $stable(pin_o) && $stable(pin_oe) && $stable(periph_in))
		else $error("pin outputs moved while frozen");

	////////////////////////////////////////////////////////////////////////
	// Pad-side checks beyond the basic drive rules

	// General-purpose outputs carry the latch value
	gp_out_value_a: assert property (
		ce |=> (pin_o & $past(gp_out_m)) == ($past(latch_reg) & $past(gp_out_m)))
		else $error("output pin value differs from latch");

	// Open-drain pins holding a low latch bit must pull
	od_low_drive_a: assert property (
		ce |=> (pin_oe & $past(od_lo_m)) == $past(od_lo_m))
		else $error("open-drain low pin not pulled");

	// An enabled open-drain pin never shows a high value
	od_never_high_a: assert property (
		ce |=> (pin_oe & pin_o & $past(od_reg)) == `EGP_RST_BYTE)
		else $error("open-drain pin enabled high");

	// Peripheral enable decides a push-pull pin it owns
	periph_oe_a: assert property (
		ce |=> (pin_oe & $past(periph_sel) & ~$past(od_reg))
			== ($past(periph_oe) & $past(periph_sel) & ~$past(od_reg)))
		else $error("peripheral enable not followed");

	// Peripheral pins without enable stay released
	periph_release_a: assert property (
		ce |=> (pin_oe & $past(periph_sel & ~periph_oe)) == `EGP_RST_BYTE)
		else $error("released peripheral pin driven");

	// Main scenarios worth seeing at least once
	wr_latch_c: cover property (wr_commit && sel_reg_now == EGP_REG_LATCH);
	rd_level_c: cover property (wb_ack_o && !wb_we_i && sel_reg_now == EGP_REG_LEVEL && dir_reg != `EGP_RST_BYTE);
	od_low_c: cover property (|(pin_oe & od_reg));
	periph_c: cover property (|(periph_sel & periph_oe));
	freeze_c: cover property (!ce && |pin_oe);
endmodule : egp_top
`default_nettype wire

// ### rtl/egp_consts.svh
// Constants of the eight-pin general-purpose port: offsets, fields, reset values.
`ifndef EGP_CONSTS_SVH
`define EGP_CONSTS_SVH

// Register byte offsets on the Wishbone bus
`define EGP_OFF_DIR 4'h0
`define EGP_OFF_LATCH 4'h4
`define EGP_OFF_LEVEL 4'h8
`define EGP_OFF_OD 4'hc

// Field layout: one byte in the low lane
`define EGP_MSB 7
`define EGP_LANE 0
`define EGP_PINS 8

// Reset and read values
`define EGP_RST_BYTE 8'h00
`define EGP_DIR_READ 8'h00
`define EGP_ZERO_WORD 32'h0000_0000
`define EGP_UPPER_ZERO 24'h00_0000

`endif

// ### rtl/egp_pkg.sv
// Types and address decoding of the eight-pin general-purpose port.
`default_nettype none
`include "egp_consts.svh"
package egp_pkg;
	typedef logic [`EGP_MSB:0] egp_byte_t;
	typedef enum {EGP_REG_DIR, EGP_REG_LATCH, EGP_REG_LEVEL, EGP_REG_OD, EGP_REG_NONE} egp_reg_t;
	typedef enum {EGP_BUS_IDLE, EGP_BUS_ACK} egp_bus_t;

	// Byte address to register selector
	function automatic egp_reg_t egp_decode(input logic [3:0] adr);
		egp_reg_t r;
		r = EGP_REG_NONE;
		case (adr)
			`EGP_OFF_DIR: r = EGP_REG_DIR;
			`EGP_OFF_LATCH: r = EGP_REG_LATCH;
			`EGP_OFF_LEVEL: r = EGP_REG_LEVEL;
			`EGP_OFF_OD: r = EGP_REG_OD;
			default: r = EGP_REG_NONE;
		endcase
		return r;
	endfunction : egp_decode
endpackage : egp_pkg
`default_nettype wire

// ### rtl/egp_sync.sv
// Three-stage pin synchroniser that accepts a level once stages two and three agree.
`default_nettype none
module egp_sync (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic pin,
	output logic level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic level_next;

	// Stage one is read only by stage two
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end else if (ce) begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	// Hold the old level while the late stages disagree
	assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
	assign level = level_reg;
endmodule : egp_sync
`default_nettype wire

// ### verification/egp_pad_model.sv
// Pad model: resolves each pin from the port drive, an external driver and a pull-up.
`default_nettype none
module egp_pad_model (
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// Port drive wins, then the outside driver, else the pull-up; contention is not modelled
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_level[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule : egp_pad_model
`default_nettype wire

// ### verification/egp_top_test.sv
// Self-checking bench of the eight-pin port: bus, pads and peripheral hand-over.
`default_nettype none
module egp_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [7:0] pin_i, pin_o, pin_oe, periph_sel, periph_out, periph_oe, periph_in, ext_en, ext_val, q;
	logic [31:0] qw;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;

	egp_top dut (.mclk, .nrst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .pin_i, .pin_o, .pin_oe, .periph_sel, .periph_out, .periph_oe, .periph_in);
	egp_pad_model pads (.pin_o, .pin_oe, .ext_en, .ext_val, .pin_level(pin_i));

	////////////////////////////////////////
	// Clock and a hang guard well beyond the roughly 120 cycles used
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			report_and_stop();
		end
	end

	////////////////////////////////////////
	// Classic single cycle; ack is read before this edge's updates land
	task automatic bus(input logic [3:0] a, input logic w, input logic [3:0] s, input logic [7:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h000000, d};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		qw = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////
	task automatic t_reset();
		check(pin_oe, 8'h00);
		bus(4'h0, 1'b0, 4'hf, 8'h00);
		check(q, 8'h00);
		bus(4'h4, 1'b0, 4'hf, 8'h00);
		check(q, 8'h00);
		bus(4'hc, 1'b0, 4'hf, 8'h00);
		check(q, 8'h00);
		bus(4'h8, 1'b0, 4'hf, 8'h00);
		check(q, 8'hff);
		$display("reset test done");
	endtask : t_reset

	task automatic t_gpio();
		ext_en <= 8'hf0;
		ext_val <= 8'h3c;
		bus(4'h0, 1'b1, 4'h1, 8'h0f);
		bus(4'h4, 1'b1, 4'h1, 8'ha5);
		tick(6);
		check(pin_oe, 8'h0f);
		check(pin_o & 8'h0f, 8'h05);
		bus(4'h4, 1'b0, 4'hf, 8'h00);
		check(q, 8'ha5);
		bus(4'h8, 1'b0, 4'hf, 8'h00);
		check(q, 8'h35);
		check(qw[31:24] | qw[23:16] | qw[15:8], 8'h00);
		$display("gpio test done");
	endtask : t_gpio

	task automatic t_refuse();
		bus(4'h8, 1'b1, 4'h1, 8'h00);
		bus(4'h4, 1'b1, 4'h0, 8'h00);
		bus(4'h1, 1'b0, 4'hf, 8'h00);
		check(q, 8'h00);
		bus(4'h8, 1'b0, 4'hf, 8'h00);
		check(q, 8'h35);
		bus(4'h4, 1'b0, 4'hf, 8'h00);
		check(q, 8'ha5);
		$display("refusal test done");
	endtask : t_refuse

	task automatic t_od();
		bus(4'hc, 1'b1, 4'h1, 8'h0f);
		tick(3);
		check(pin_oe, 8'h0a);
		check(pin_o & 8'h0a, 8'h00);
		bus(4'hc, 1'b0, 4'hf, 8'h00);
		check(q, 8'h0f);
		$display("open drain test done");
	endtask : t_od

	task automatic t_periph();
		bus(4'hc, 1'b1, 4'h1, 8'h00);
		bus(4'h0, 1'b1, 4'h1, 8'h00);
		periph_sel <= 8'h80;
		periph_oe <= 8'h80;
		periph_out <= 8'h00;
		tick(6);
		check(pin_oe, 8'h80);
		check(pin_o & 8'h80, 8'h00);
		check(periph_in, 8'h3f);
		$display("peripheral test done");
	endtask : t_periph

	// Mid-run reset must clear every register and release the pins
	task automatic t_rereset();
		nrst <= 1'b0;
		tick(2);
		nrst <= 1'b1;
		tick(6);
		check(pin_oe, 8'h00);
		bus(4'h4, 1'b0, 4'hf, 8'h00);
		check(q, 8'h00);
		bus(4'hc, 1'b0, 4'hf, 8'h00);
		check(q, 8'h00);
		$display("second reset test done");
	endtask : t_rereset

	// Low clock enable freezes synchronisers and pads
	task automatic t_freeze();
		ce <= 1'b0;
		ext_val <= 8'hff;
		tick(6);
		check(periph_in, 8'h3f);
		check(pin_oe, 8'h80);
		ce <= 1'b1;
		tick(6);
		check(periph_in, 8'h7f);
		$display("freeze test done");
	endtask : t_freeze

	////////////////////////////////////////
	// Inputs idle at time zero, reset held for twenty cycles
	initial begin
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
		ce = 1'b1;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		{periph_sel, periph_out, periph_oe, ext_en, ext_val} = 40'h0000000000;
		tick(20);
		nrst <= 1'b1;
		tick(6);
		t_reset();
		t_gpio();
		t_refuse();
		t_od();
		t_rereset();
		t_periph();
		t_freeze();
		report_and_stop();
	end
endmodule : egp_top_test
`default_nettype wire
